// *** design/bank_check_pkg.sv ***
package bank_check_pkg;
  // ==========================================
  // Geometry and timing (clock cycles)
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam logic [3:0] BURST_LENGTH = 4'h4;
  localparam logic [3:0] HALF_BURST = 4'h2;
  localparam logic [3:0] WRITE_LATENCY = 4'h3;
  localparam logic [3:0] READ_LATENCY_ROUNDED_UP = 4'h7;
  localparam logic [3:0] WRITE_TO_READ_TURNAROUND = 4'h2;
  localparam logic [3:0] PRECHARGE_PERIOD = 4'hA;
  localparam logic [3:0] ACTIVATE_TO_ACCESS_DELAY = 4'hA;
  localparam logic [3:0] WRITE_RECOVERY_INTERVAL = 4'h6;
  localparam logic [7:0] SELF_REFRESH_EXIT_DELAY = 8'h10;
  // Read with auto precharge: earliest precharge after the read command
  localparam logic [3:0] READ_AP_ACCESS = 4'h2;
  // Write with auto precharge: latency, burst, then recovery
  localparam logic [4:0] WRITE_AP_ACCESS = 5'h0B;
  // Cross-bank spacing after an auto-precharge access
  localparam logic [4:0] GAP_WAP_TO_READ = 5'h07;
  localparam logic [4:0] GAP_WAP_TO_WRITE = 5'h02;
  localparam logic [4:0] GAP_RAP_TO_READ = 5'h02;
  localparam logic [4:0] GAP_RAP_TO_WRITE = 5'h07;
  localparam logic [4:0] GAP_AP_TO_ROW = 5'h01;

  // ==========================================
  // Commands and bank states
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_ACTIVE = 3'h1, CMD_READ = 3'h2, CMD_WRITE = 3'h3,
    CMD_PRECHARGE = 3'h4, CMD_REFRESH = 3'h5, CMD_MODE_LOAD = 3'h6, CMD_TERM_OFF = 3'h7
  } cmd_t;

  typedef enum logic [2:0] {
    BANK_IDLE = 3'h0, BANK_ACTIVATING = 3'h1, BANK_ROW_ACTIVE = 3'h3,
    BANK_BURST = 3'h2, BANK_AP_ACCESS = 3'h6, BANK_PRECHARGING = 3'h7
  } bank_state_t;

  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_enable_n;
    logic auto_precharge;
    logic [1:0] bank;
  } cmd_pins_t;

  typedef struct packed {
    logic accepted;
    logic illegal;
    logic [2:0] cmd;
    logic [1:0] bank;
  } verdict_t;
endpackage

// *** design/bank_tracker.sv ***
module bank_tracker (
  // Clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Accepted command aimed at this bank; burst_cut marks a burst taken in another bank
  input wire logic hit,
  input wire logic [2:0] cmd,
  input wire logic auto_precharge,
  input wire logic burst_cut,
  // State out
  output bank_check_pkg::bank_state_t state,
  output logic in_precharge_window
);
  // ==========================================
  // Per-bank state and counter
  bank_check_pkg::bank_state_t state_r;
  logic [4:0] count_r;
  logic ap_window_r;

  assign state = state_r;
  assign in_precharge_window = ap_window_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= bank_check_pkg::BANK_IDLE;
      count_r <= 5'h00;
      ap_window_r <= 1'b0;
    end else if (clock_enable) begin
      if (hit && cmd == bank_check_pkg::CMD_ACTIVE) begin
        state_r <= bank_check_pkg::BANK_ACTIVATING;
        count_r <= {1'b0, bank_check_pkg::ACTIVATE_TO_ACCESS_DELAY};
      end else if (hit && cmd == bank_check_pkg::CMD_PRECHARGE) begin
        state_r <= bank_check_pkg::BANK_PRECHARGING;
        count_r <= {1'b0, bank_check_pkg::PRECHARGE_PERIOD};
        ap_window_r <= 1'b0;
      end else if (hit && (cmd == bank_check_pkg::CMD_READ || cmd == bank_check_pkg::CMD_WRITE)) begin
        if (auto_precharge) begin
          // access part first, then the precharge period
          state_r <= bank_check_pkg::BANK_AP_ACCESS;
          count_r <= (cmd == bank_check_pkg::CMD_READ) ?
                     {1'b0, bank_check_pkg::READ_AP_ACCESS} : bank_check_pkg::WRITE_AP_ACCESS;
        end else begin
          state_r <= bank_check_pkg::BANK_BURST;
          count_r <= {1'b0, bank_check_pkg::HALF_BURST};
        end
      end else if (burst_cut && state_r == bank_check_pkg::BANK_BURST) begin
        // a burst elsewhere ends this one
        state_r <= bank_check_pkg::BANK_ROW_ACTIVE;
        count_r <= 5'h00;
      end else if (count_r != 5'h00) begin
        count_r <= count_r - 5'h01;
      end else begin
        unique case (state_r)
          bank_check_pkg::BANK_ACTIVATING: state_r <= bank_check_pkg::BANK_ROW_ACTIVE;
          bank_check_pkg::BANK_BURST: state_r <= bank_check_pkg::BANK_ROW_ACTIVE;
          bank_check_pkg::BANK_AP_ACCESS: begin
            state_r <= bank_check_pkg::BANK_PRECHARGING;
            count_r <= {1'b0, bank_check_pkg::PRECHARGE_PERIOD};
            ap_window_r <= 1'b1;
          end
          bank_check_pkg::BANK_PRECHARGING: begin
            state_r <= bank_check_pkg::BANK_IDLE;
            ap_window_r <= 1'b0;
          end
          bank_check_pkg::BANK_IDLE, bank_check_pkg::BANK_ROW_ACTIVE: state_r <= state_r;
          default: state_r <= bank_check_pkg::BANK_IDLE;
        endcase
      end
    end
  end
endmodule // bank_tracker

// *** design/multibank_command_legality_checker.sv ***
// Notes on behaviour
// - Chip select high is a deselect; nothing new taken, work continues.
// - Select low with all strobes high is a no-operation.
// - Termination disable decodes only with chip select high; with select low the same strobes decode as READ.
// - Row strobe low, column high: ACTIVE, or PRECHARGE with write enable low.
// - Row high, column low: READ, or WRITE with write enable low.
// - Cross-bank check assumes the target bank itself permits the command.
// - Idle other bank restricts nothing.
// - Busy other bank still allows ACTIVE, READ, WRITE, PRECHARGE; new burst cuts old.
// - Checks only with clock enable high twice and self refresh exit elapsed.
// - Idle only after precharge period has fully run.
// - Row active once activate-to-access delay passed and no burst.
// - Read with auto precharge: access part then precharge at earliest point.
// - Write with auto precharge: precharge starts after write recovery.
// - During auto precharge period other banks take row and column commands.
// - Anything else is illegal and flagged, not acted on.
// - Reads and writes may carry auto precharge or not.
module multibank_command_legality_checker (
  // Clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Command pins from the controller
  input wire bank_check_pkg::cmd_pins_t pins,
  input wire logic self_refresh_exit,
  // Verdict
  output bank_check_pkg::verdict_t verdict,
  output logic [11:0] bank_states,
  output logic all_banks_idle
);
  // ==========================================
  // Decode
  bank_check_pkg::cmd_t cmd;
  logic cke_prev_r;
  logic [7:0] exit_count_r;
  logic gate_open;
  bank_check_pkg::bank_state_t state [bank_check_pkg::NUM_BANKS];
  logic [bank_check_pkg::NUM_BANKS-1:0] ap_window;
  logic [bank_check_pkg::NUM_BANKS-1:0] hit;
  logic idle_all;
  logic legal;
  logic own_ok;
  logic cross_ok;
  logic burst_start;
  logic [4:0] gap_r;
  logic last_ap_write_r;
  logic last_ap_read_r;
  logic [1:0] last_bank_r;
  logic [4:0] need;
  logic [bank_check_pkg::NUM_BANKS-1:0] precharging;
  logic [3:0] strobes;

  always_comb begin
    cmd = bank_check_pkg::CMD_NOP;
    if (pins.row_strobe_n && !pins.column_strobe_n && pins.write_enable_n) begin
      cmd = pins.chip_select_n ? bank_check_pkg::CMD_TERM_OFF : bank_check_pkg::CMD_READ;
    end else if (pins.chip_select_n) begin
      cmd = bank_check_pkg::CMD_NOP;
    end else begin
      unique case ({pins.row_strobe_n, pins.column_strobe_n, pins.write_enable_n})
        3'h7: cmd = bank_check_pkg::CMD_NOP;
        3'h3: cmd = bank_check_pkg::CMD_ACTIVE;
        3'h2: cmd = bank_check_pkg::CMD_PRECHARGE;
        3'h4: cmd = bank_check_pkg::CMD_WRITE;
        3'h1: cmd = bank_check_pkg::CMD_REFRESH;
        3'h0: cmd = bank_check_pkg::CMD_MODE_LOAD;
        3'h6: cmd = bank_check_pkg::CMD_NOP;
        3'h5: cmd = bank_check_pkg::CMD_READ;
      endcase
    end
  end

  // ==========================================
  // Clock enable history and self refresh exit
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cke_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= clock_enable;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      exit_count_r <= 8'h00;
    end else if (clock_enable) begin
      if (self_refresh_exit) begin
        exit_count_r <= bank_check_pkg::SELF_REFRESH_EXIT_DELAY;
      end else if (exit_count_r != 8'h00) begin
        exit_count_r <= exit_count_r - 8'h01;
      end
    end
  end

  assign gate_open = clock_enable && cke_prev_r && (exit_count_r == 8'h00);

  // ==========================================
  // Per-bank trackers
  genvar b;
  generate
    for (b = 0; b < bank_check_pkg::NUM_BANKS; b++) begin : g_bank
      assign hit[b] = legal && (pins.bank == 2'(b));
      bank_tracker u_bank (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .hit(hit[b]),
        .cmd(cmd),
        .auto_precharge(pins.auto_precharge),
        .burst_cut(burst_start && (pins.bank != 2'(b))),
        .state(state[b]),
        .in_precharge_window(ap_window[b])
      );
      assign bank_states[3*b +: 3] = state[b];
      assign precharging[b] = (state[b] == bank_check_pkg::BANK_PRECHARGING);
    end
  endgenerate

  assign idle_all = (state[0] == bank_check_pkg::BANK_IDLE) && (state[1] == bank_check_pkg::BANK_IDLE)
                 && (state[2] == bank_check_pkg::BANK_IDLE) && (state[3] == bank_check_pkg::BANK_IDLE);

  // ==========================================
  // Legality
  always_comb begin
    own_ok = 1'b0;
    unique case (cmd)
      bank_check_pkg::CMD_ACTIVE: own_ok = (state[pins.bank] == bank_check_pkg::BANK_IDLE);
      bank_check_pkg::CMD_READ, bank_check_pkg::CMD_WRITE:
        own_ok = (state[pins.bank] == bank_check_pkg::BANK_ROW_ACTIVE)
              || (state[pins.bank] == bank_check_pkg::BANK_BURST);
      bank_check_pkg::CMD_PRECHARGE:
        own_ok = (state[pins.bank] == bank_check_pkg::BANK_ROW_ACTIVE)
              || (state[pins.bank] == bank_check_pkg::BANK_IDLE);
      bank_check_pkg::CMD_REFRESH, bank_check_pkg::CMD_MODE_LOAD: own_ok = idle_all;
      bank_check_pkg::CMD_NOP, bank_check_pkg::CMD_TERM_OFF: own_ok = 1'b0;
    endcase
  end

  // Spacing after an auto-precharge access on another bank
  always_comb begin
    need = 5'h00;
    if (last_bank_r != pins.bank) begin
      if (last_ap_write_r) begin
        unique case (cmd)
          bank_check_pkg::CMD_READ: need = bank_check_pkg::GAP_WAP_TO_READ;
          bank_check_pkg::CMD_WRITE: need = bank_check_pkg::GAP_WAP_TO_WRITE;
          default: need = bank_check_pkg::GAP_AP_TO_ROW;
        endcase
      end else if (last_ap_read_r) begin
        unique case (cmd)
          bank_check_pkg::CMD_READ: need = bank_check_pkg::GAP_RAP_TO_READ;
          bank_check_pkg::CMD_WRITE: need = bank_check_pkg::GAP_RAP_TO_WRITE;
          default: need = bank_check_pkg::GAP_AP_TO_ROW;
        endcase
      end
    end
  end

  // no other bank state forbids row or column commands
  assign cross_ok = (gap_r >= need);
  assign legal = gate_open && own_ok && cross_ok;
  assign burst_start = legal
                    && (cmd == bank_check_pkg::CMD_READ || cmd == bank_check_pkg::CMD_WRITE);

  // Gap counts clocks since the last auto-precharge access; saturates
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gap_r <= 5'h1F;
      last_ap_write_r <= 1'b0;
      last_ap_read_r <= 1'b0;
      last_bank_r <= 2'h0;
    end else if (clock_enable) begin
      if (burst_start && pins.auto_precharge) begin
        gap_r <= 5'h01;
        last_ap_write_r <= (cmd == bank_check_pkg::CMD_WRITE);
        last_ap_read_r <= (cmd == bank_check_pkg::CMD_READ);
        last_bank_r <= pins.bank;
      end else if (gap_r != 5'h1F) begin
        gap_r <= gap_r + 5'h01;
      end
    end
  end

  // ==========================================
  // Registered verdict; unknown or ill-timed commands are flagged only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      verdict <= '0;
      all_banks_idle <= 1'b1;
    end else if (clock_enable) begin
      verdict.accepted <= legal;
      verdict.illegal <= gate_open && !legal && (cmd != bank_check_pkg::CMD_NOP)
                      && (cmd != bank_check_pkg::CMD_TERM_OFF);
      verdict.cmd <= cmd;
      verdict.bank <= pins.bank;
      all_banks_idle <= idle_all;
    end
  end

  // ==========================================
  // Checks
  AST_DESELECT_IGNORED: assert property (@(posedge clock) disable iff (reset)
    pins.chip_select_n |-> !legal)
    else $error("deselect accepted");
  AST_WAP_READ_GAP: assert property (@(posedge clock) disable iff (reset)
    (legal && cmd == bank_check_pkg::CMD_READ && last_ap_write_r && last_bank_r != pins.bank)
      |-> gap_r >= 5'h07)
    else $error("read too soon after write with auto precharge");
  AST_RAP_WRITE_GAP: assert property (@(posedge clock) disable iff (reset)
    (legal && cmd == bank_check_pkg::CMD_WRITE && last_ap_read_r && last_bank_r != pins.bank)
      |-> gap_r >= 5'h07)
    else $error("write too soon after read with auto precharge");
  AST_REFRESH_IDLE: assert property (@(posedge clock) disable iff (reset)
    (legal && cmd == bank_check_pkg::CMD_REFRESH) |-> idle_all)
    else $error("refresh with bank open");
  AST_CKE_GATE: assert property (@(posedge clock) disable iff (reset)
    !cke_prev_r |-> !legal)
    else $error("command taken right after clock enable rose");
  AST_ACCEPT_FLAG: assert property (@(posedge clock) disable iff (reset)
    clock_enable && legal |=> verdict.accepted && !verdict.illegal)
    else $error("accept not reported");
  sequence s_activate_b0;
    clock_enable && hit[0] && cmd == bank_check_pkg::CMD_ACTIVE;
  endsequence
  AST_ACTIVATE_DELAY: assert property (@(posedge clock) disable iff (reset)
    s_activate_b0 |=> (state[0] == bank_check_pkg::BANK_ACTIVATING) [*8])
    else $error("row active before activate delay");
  AST_PRECHARGE_IDLE: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && hit[1] && cmd == bank_check_pkg::CMD_PRECHARGE)
      |=> (state[1] != bank_check_pkg::BANK_IDLE) [*8])
    else $error("idle before precharge period");

  // ==========================================
  // Decode checks
  assign strobes = {pins.chip_select_n, pins.row_strobe_n, pins.column_strobe_n,
                    pins.write_enable_n};
  AST_DECODE_ACTIVE: assert property (@(posedge clock) disable iff (reset)
    (strobes == 4'h3) |-> cmd == bank_check_pkg::CMD_ACTIVE)
    else $error("activate not decoded");
  AST_DECODE_PRECHARGE: assert property (@(posedge clock) disable iff (reset)
    (strobes == 4'h2) |-> cmd == bank_check_pkg::CMD_PRECHARGE)
    else $error("precharge not decoded");
  AST_DECODE_READ: assert property (@(posedge clock) disable iff (reset)
    (strobes == 4'h5) |-> cmd == bank_check_pkg::CMD_READ)
    else $error("read not decoded");
  AST_DECODE_WRITE: assert property (@(posedge clock) disable iff (reset)
    (strobes == 4'h4) |-> cmd == bank_check_pkg::CMD_WRITE)
    else $error("write not decoded");
  AST_DECODE_NOP: assert property (@(posedge clock) disable iff (reset)
    (strobes == 4'h7) |-> cmd == bank_check_pkg::CMD_NOP)
    else $error("no-operation not decoded");
  AST_DECODE_TERM_OFF: assert property (@(posedge clock) disable iff (reset)
    (strobes == 4'hD) |-> cmd == bank_check_pkg::CMD_TERM_OFF)
    else $error("termination disable not decoded");

  // ==========================================
  // Verdict checks
  AST_DESELECT_QUIET: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && pins.chip_select_n) |=> !verdict.accepted && !verdict.illegal)
    else $error("deselect produced a verdict");
  AST_TERM_OFF_QUIET: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && cmd == bank_check_pkg::CMD_TERM_OFF) |=> !verdict.accepted && !verdict.illegal)
    else $error("termination disable produced a verdict");
  AST_ILLEGAL_FLAG: assert property (@(posedge clock) disable iff (reset)
    (gate_open && !legal && cmd == bank_check_pkg::CMD_ACTIVE)
      |=> verdict.illegal && !verdict.accepted)
    else $error("refused activate not flagged");
  AST_REFUSED_NO_CHANGE: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && !hit[0] && state[0] == bank_check_pkg::BANK_IDLE)
      |=> state[0] == bank_check_pkg::BANK_IDLE)
    else $error("idle bank moved without a taken command");
  AST_IDLE_REPORT: assert property (@(posedge clock) disable iff (reset)
    clock_enable |=> all_banks_idle == $past(idle_all))
    else $error("all banks idle flag wrong");
  AST_VERDICT_ECHO: assert property (@(posedge clock) disable iff (reset)
    clock_enable |=> (verdict.cmd == $past(cmd))
      && (verdict.bank == $past(pins.bank)))
    else $error("verdict does not echo the command");

  // ==========================================
  // Bank and spacing checks
  sequence s_read_ap_b0;
    clock_enable && hit[0] && cmd == bank_check_pkg::CMD_READ && pins.auto_precharge;
  endsequence
  sequence s_write_ap_b0;
    clock_enable && hit[0] && cmd == bank_check_pkg::CMD_WRITE && pins.auto_precharge;
  endsequence
  sequence s_cut_b1;
    clock_enable && burst_start && pins.bank != 2'h1 && state[1] == bank_check_pkg::BANK_BURST;
  endsequence
  sequence s_exit_start;
    clock_enable && self_refresh_exit;
  endsequence

  AST_READ_AP_ACCESS: assert property (@(posedge clock) disable iff (reset)
    s_read_ap_b0 |=> (state[0] == bank_check_pkg::BANK_AP_ACCESS) [*3])
    else $error("read auto precharge access part too short");
  AST_WRITE_AP_ACCESS: assert property (@(posedge clock) disable iff (reset)
    s_write_ap_b0 |=> (state[0] == bank_check_pkg::BANK_AP_ACCESS) [*8])
    else $error("write auto precharge recovery too short");
  AST_BURST_CUT: assert property (@(posedge clock) disable iff (reset)
    s_cut_b1 |=> state[1] == bank_check_pkg::BANK_ROW_ACTIVE)
    else $error("burst not ended by a burst in another bank");
  AST_EXIT_BLOCKS: assert property (@(posedge clock) disable iff (reset)
    s_exit_start |=> (!legal) [*8])
    else $error("command taken during self refresh exit");
  AST_WINDOW_IN_PRECHARGE: assert property (@(posedge clock) disable iff (reset)
    (ap_window & ~precharging) == '0)
    else $error("precharge window outside precharge period");
  AST_WINDOW_ACCEPTS: assert property (@(posedge clock) disable iff (reset)
    (ap_window[0] && gate_open && pins.bank != 2'h0 && own_ok && cross_ok
      && cmd inside {bank_check_pkg::CMD_ACTIVE, bank_check_pkg::CMD_PRECHARGE,
                     bank_check_pkg::CMD_READ, bank_check_pkg::CMD_WRITE}) |-> legal)
    else $error("other bank refused during precharge period");
  AST_COLUMN_NEEDS_ROW: assert property (@(posedge clock) disable iff (reset)
    (legal && (cmd == bank_check_pkg::CMD_READ || cmd == bank_check_pkg::CMD_WRITE))
      |-> (state[pins.bank] == bank_check_pkg::BANK_ROW_ACTIVE
        || state[pins.bank] == bank_check_pkg::BANK_BURST))
    else $error("column command without open row");
  AST_IDLE_FREE: assert property (@(posedge clock) disable iff (reset)
    (gate_open && own_ok && gap_r == 5'h1F) |-> legal)
    else $error("command refused with no other bank restriction");
  AST_MODE_LOAD_IDLE: assert property (@(posedge clock) disable iff (reset)
    (legal && cmd == bank_check_pkg::CMD_MODE_LOAD) |-> idle_all)
    else $error("mode load with bank open");
  AST_WAP_WRITE_GAP: assert property (@(posedge clock) disable iff (reset)
    (legal && cmd == bank_check_pkg::CMD_WRITE && last_ap_write_r && last_bank_r != pins.bank)
      |-> gap_r >= 5'h02)
    else $error("write too soon after write with auto precharge");
  AST_RAP_READ_GAP: assert property (@(posedge clock) disable iff (reset)
    (legal && cmd == bank_check_pkg::CMD_READ && last_ap_read_r && last_bank_r != pins.bank)
      |-> gap_r >= 5'h02)
    else $error("read too soon after read with auto precharge");
  AST_AP_ROW_GAP: assert property (@(posedge clock) disable iff (reset)
    (legal && (cmd == bank_check_pkg::CMD_ACTIVE || cmd == bank_check_pkg::CMD_PRECHARGE)
      && (last_ap_write_r || last_ap_read_r) && last_bank_r != pins.bank)
      |-> gap_r >= 5'h01)
    else $error("row command in the clock of an auto precharge access");
endmodule // multibank_command_legality_checker

// *** verification/ctrl_model.sv ***
// ==========================================
// Controller side: turns a requested command into pin levels
module ctrl_model (
  // Request from the bench
  input wire logic issue,
  input wire bank_check_pkg::cmd_t op,
  input wire logic [1:0] bank,
  input wire logic ap,
  // Command pins
  output bank_check_pkg::cmd_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Encoding
  always_comb begin
    // Idle bus: deselect; released lines show the inverse so stale values never match
    pins = '{1'b1, 1'b1, 1'b1, 1'b1, ~ap, ~bank};
    if (issue) begin
      pins.chip_select_n = 1'b0;
      pins.auto_precharge = ap;
      pins.bank = bank;
      case (op)
        bank_check_pkg::CMD_ACTIVE: pins.row_strobe_n = 1'b0;
        bank_check_pkg::CMD_PRECHARGE: {pins.row_strobe_n, pins.write_enable_n} = 2'h0;
        bank_check_pkg::CMD_READ: pins.column_strobe_n = 1'b0;
        bank_check_pkg::CMD_WRITE: {pins.column_strobe_n, pins.write_enable_n} = 2'h0;
        bank_check_pkg::CMD_REFRESH: {pins.row_strobe_n, pins.column_strobe_n} = 2'h0;
        bank_check_pkg::CMD_MODE_LOAD: pins[5:3] = 3'h0;
        // Chip select left high on purpose: with it low this encoding decodes as READ
        bank_check_pkg::CMD_TERM_OFF: {pins.chip_select_n, pins.column_strobe_n} = 2'h2;
        default: ;
      endcase
    end
  end
endmodule // ctrl_model

// *** verification/multibank_command_legality_checker_bench.sv ***
// ==========================================
// Bench top
module multibank_command_legality_checker_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, clock_enable, self_refresh_exit, issue, ap;
  logic [1:0] bnk;
  logic [11:0] bank_states;
  logic all_banks_idle;
  bank_check_pkg::cmd_t op;
  bank_check_pkg::cmd_pins_t pins;
  bank_check_pkg::verdict_t verdict;
  int err_total, check_count;

  multibank_command_legality_checker u_multibank_command_legality_checker (.clock(clock),
    .reset(reset), .clock_enable(clock_enable), .pins(pins),
    .self_refresh_exit(self_refresh_exit), .verdict(verdict), .bank_states(bank_states),
    .all_banks_idle(all_banks_idle));
  ctrl_model u_ctrl_model (.issue(issue), .op(op), .bank(bnk), .ap(ap), .pins(pins));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================
  // Shared tasks
  task check(string name, logic [11:0] seen, logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task cst(int b, bank_check_pkg::bank_state_t s);
    check("state", 12'(bank_states[3*b +: 3]), 12'(s));
  endtask
  // Called at a falling edge; leaves the request up so back-to-back calls hit adjacent edges
  task send(bank_check_pkg::cmd_t o, logic [1:0] b, logic a, logic [1:0] exp);
    op = o;
    bnk = b;
    ap = a;
    issue = 1'b1;
    @(negedge clock);
    check("verdict", 12'({verdict.accepted, verdict.illegal}), 12'(exp));
    if (exp == 2'h2) check("cmd", 12'({verdict.cmd, verdict.bank}), 12'({o, b}));
  endtask
  task idle(int n);
    issue = 1'b0;
    repeat (n) @(negedge clock);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task t_decode;
    send(bank_check_pkg::CMD_ACTIVE, 2'h0, 1'b0, 2'h2);
    cst(0, bank_check_pkg::BANK_ACTIVATING);
    send(bank_check_pkg::CMD_READ, 2'h0, 1'b0, 2'h1);
    idle(10);
    cst(0, bank_check_pkg::BANK_ROW_ACTIVE);
    send(bank_check_pkg::CMD_READ, 2'h0, 1'b0, 2'h2);
    cst(0, bank_check_pkg::BANK_BURST);
    send(bank_check_pkg::CMD_NOP, 2'h0, 1'b0, 2'h0);
    idle(3);
    cst(0, bank_check_pkg::BANK_ROW_ACTIVE);
    check("desel", 12'(verdict.accepted), 12'h0);
    send(bank_check_pkg::CMD_WRITE, 2'h0, 1'b0, 2'h2);
    idle(8);
    send(bank_check_pkg::CMD_PRECHARGE, 2'h0, 1'b0, 2'h2);
    cst(0, bank_check_pkg::BANK_PRECHARGING);
    send(bank_check_pkg::CMD_ACTIVE, 2'h0, 1'b0, 2'h1);
    idle(11);
    cst(0, bank_check_pkg::BANK_IDLE);
    send(bank_check_pkg::CMD_TERM_OFF, 2'h0, 1'b0, 2'h0);
    check("term", 12'(verdict.cmd), 12'(bank_check_pkg::CMD_TERM_OFF));
    idle(1);
    $display("test decode done");
  endtask

  task t_cross;
    for (int b = 0; b < 4; b++) send(bank_check_pkg::CMD_ACTIVE, 2'(b), 1'b0, 2'h2);
    idle(11);
    send(bank_check_pkg::CMD_WRITE, 2'h0, 1'b1, 2'h2);
    send(bank_check_pkg::CMD_PRECHARGE, 2'h3, 1'b0, 2'h2);
    send(bank_check_pkg::CMD_WRITE, 2'h1, 1'b0, 2'h2);
    idle(3);
    send(bank_check_pkg::CMD_READ, 2'h2, 1'b0, 2'h1);
    send(bank_check_pkg::CMD_READ, 2'h2, 1'b0, 2'h2);
    idle(30);
    cst(0, bank_check_pkg::BANK_IDLE);
    send(bank_check_pkg::CMD_ACTIVE, 2'h0, 1'b0, 2'h2);
    idle(11);
    send(bank_check_pkg::CMD_READ, 2'h0, 1'b1, 2'h2);
    send(bank_check_pkg::CMD_READ, 2'h1, 1'b0, 2'h1);
    send(bank_check_pkg::CMD_READ, 2'h1, 1'b0, 2'h2);
    send(bank_check_pkg::CMD_READ, 2'h2, 1'b0, 2'h2);
    cst(1, bank_check_pkg::BANK_ROW_ACTIVE);
    idle(2);
    send(bank_check_pkg::CMD_WRITE, 2'h2, 1'b0, 2'h1);
    send(bank_check_pkg::CMD_WRITE, 2'h2, 1'b0, 2'h2);
    send(bank_check_pkg::CMD_READ, 2'h1, 1'b0, 2'h2);
    cst(2, bank_check_pkg::BANK_ROW_ACTIVE);
    idle(30);
    send(bank_check_pkg::CMD_REFRESH, 2'h0, 1'b0, 2'h1);
    send(bank_check_pkg::CMD_PRECHARGE, 2'h1, 1'b0, 2'h2);
    send(bank_check_pkg::CMD_PRECHARGE, 2'h2, 1'b0, 2'h2);
    idle(12);
    check("idle", 12'(all_banks_idle), 12'h1);
    send(bank_check_pkg::CMD_REFRESH, 2'h0, 1'b0, 2'h2);
    send(bank_check_pkg::CMD_MODE_LOAD, 2'h0, 1'b0, 2'h2);
    idle(2);
    $display("test cross done");
  endtask

  task t_cke;
    clock_enable = 1'b0;
    op = bank_check_pkg::CMD_ACTIVE;
    bnk = 2'h0;
    issue = 1'b1;
    @(negedge clock);
    cst(0, bank_check_pkg::BANK_IDLE);
    clock_enable = 1'b1;
    @(negedge clock);
    cst(0, bank_check_pkg::BANK_IDLE);
    send(bank_check_pkg::CMD_ACTIVE, 2'h0, 1'b0, 2'h2);
    idle(2);
    self_refresh_exit = 1'b1;
    @(negedge clock);
    self_refresh_exit = 1'b0;
    bnk = 2'h1;
    issue = 1'b1;
    @(negedge clock);
    check("exit", 12'(verdict.accepted), 12'h0);
    idle(20);
    send(bank_check_pkg::CMD_ACTIVE, 2'h1, 1'b0, 2'h2);
    idle(2);
    $display("test cke done");
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    {reset, clock_enable, self_refresh_exit, issue, ap, bnk} = 7'h60;
    op = bank_check_pkg::CMD_NOP;
    err_total = 0;
    check_count = 0;
    repeat (5) @(negedge clock);
    check("reset", 12'({verdict, all_banks_idle}), 12'h1);
    check("banks", bank_states, 12'h000);
    reset = 1'b0;
    idle(2);
    t_decode;
    t_cross;
    t_cke;
    test_done;
  end
  // Whole run is about two hundred cycles; this limit only catches a hang
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    test_done;
  end
endmodule // multibank_command_legality_checker_bench
